// >>> pbs_pkg.sv
package pbs_pkg;

    // ****************************************************************
    // geometry
    // ****************************************************************
    localparam int ADDR_W  = 19;
    localparam int DATA_W  = 18;
    localparam int BYTE_W  = 9;
    localparam int LANES   = 2;
    localparam int BURST_W = 2;

    // ****************************************************************
    // lane positions
    // ****************************************************************
    localparam int LOWER_LSB = 0;
    localparam int UPPER_LSB = 9;

    // ****************************************************************
    // values after reset, and the burst counter step
    // ****************************************************************
    localparam logic [DATA_W-1:0]  DATA_RST  = 18'h0_0000;
    localparam logic [ADDR_W-1:0]  ADDR_RST  = 19'h0_0000;
    localparam logic [LANES-1:0]   LANE_RST  = 2'h0;
    localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
    localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;

    // ****************************************************************
    // pipeline state
    // ****************************************************************
    typedef struct packed {
        logic                       burstOn;
        logic                       burstWr;
        logic [ADDR_W-1:BURST_W]    burstBase;
        logic [BURST_W-1:0]         burstStart;
        logic [BURST_W-1:0]         burstCnt;
        logic                       aValid;
        logic                       aWrite;
        logic [ADDR_W-1:0]          aAddr;
        logic [LANES-1:0]           aLanes;
        logic                       bValid;
        logic                       bWrite;
        logic [ADDR_W-1:0]          bAddr;
        logic [LANES-1:0]           bLanes;
        logic                       cValid;
        logic [ADDR_W-1:0]          cAddr;
        logic [LANES-1:0]           cLanes;
        logic [DATA_W-1:0]          cData;
        logic [DATA_W-1:0]          rdData;
        logic                       drive;
        logic                       oeGate;
    } pbs_state_t;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [BURST_W-1:0] pbs_burst_addr(
        input logic [BURST_W-1:0] start,
        input logic [BURST_W-1:0] cnt,
        input logic               interleaved
    );
        pbs_burst_addr = interleaved ? (start ^ cnt) : (start + cnt);
    endfunction

    function automatic logic [DATA_W-1:0] pbs_merge(
        input logic [DATA_W-1:0] oldWord,
        input logic [DATA_W-1:0] newWord,
        input logic [LANES-1:0]  lanes
    );
        logic [DATA_W-1:0] w;
        w = oldWord;
        if (lanes[0]) begin
            w[LOWER_LSB +: BYTE_W] = newWord[LOWER_LSB +: BYTE_W];
        end
        if (lanes[1]) begin
            w[UPPER_LSB +: BYTE_W] = newWord[UPPER_LSB +: BYTE_W];
        end
        pbs_merge = w;
    endfunction

endpackage

// >>> pbs_array.sv
`timescale 1ns/1ps

module pbs_array (
    // clock
    input  wire logic                        sys_clk,
    // write side
    input  wire logic                        wrEn,
    input  wire logic [pbs_pkg::ADDR_W-1:0]  wrAddr,
    input  wire logic [pbs_pkg::LANES-1:0]   wrLanes,
    input  wire logic [pbs_pkg::DATA_W-1:0]  wrData,
    // read side
    input  wire logic [pbs_pkg::ADDR_W-1:0]  rdAddr,
    output logic      [pbs_pkg::DATA_W-1:0]  rdData
);
    import pbs_pkg::*;

    // ****************************************************************
    // storage
    // ****************************************************************
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge sys_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= pbs_merge(mem[wrAddr], wrData, wrLanes);
        end
    end

    // read is combinational; the caller registers it
    assign rdData = mem[rdAddr];

endmodule

// >>> pbs_sram_port.sv
// Functional notes
// RULE1: address captured only with load low, clock enable low, all selects true
// RULE2: two low address bits at load seed the burst counter
// RULE3: one active-low write enable per nine-bit lane, lower then upper
// RULE4: controller gives valid lane enables on load writes and burst writes
// RULE5: lane enables ignored whenever read/write select samples high; here advances of a write burst use lane enables whatever it samples
// RULE6: selected lanes written with data arriving two cycles after command
// RULE7: controller may tie lane enables low for full-word writes
// RULE8: clock enable high freezes everything as if the edge never came; here oeGate still samples output enable and sleep on such edges
// RULE9: controller holds clock enable low on every edge meant to act
// RULE10: direction taken at load holds for following burst advances
// RULE11: data transfer happens two cycles after the command cycle
// RULE12: all behaviour on rising edge except output enable, sleep, order
// RULE13: load with any select false starts a deselect cycle
// RULE14: data bus floats two cycles after the deselect cycle
// RULE15: second select behaves like the others but is active high
// RULE16: read data driven only while output enable is low
// RULE17: controller may hold output enable low permanently
// RULE18: load while selected loads new address and control
// RULE19: advance steps the burst counter of a running burst
// RULE20: address and direction ignored while advancing
// RULE21: order input high gives interleaved, low gives linear bursts
// RULE22: data input and output paths are registered
// RULE23: two-bit counter, four-word burst wrapping in its block
`timescale 1ns/1ps

module pbs_sram_port (
    // clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        arst_n,
    // command inputs
    input  wire logic [pbs_pkg::ADDR_W-1:0]  address,
    input  wire logic                        loadAdvance,
    input  wire logic                        readNotWrite,
    input  wire logic                        lowerByteWrite_n,
    input  wire logic                        upperByteWrite_n,
    input  wire logic                        clockEnable_n,
    // chip selects
    input  wire logic                        chipSelect_n,
    input  wire logic                        chipSelectSecond,
    input  wire logic                        chipSelectThird_n,
    // static and asynchronous controls
    input  wire logic                        outputEnable_n,
    input  wire logic                        sleepRequest,
    input  wire logic                        burstOrder,
    // data bus
    input  wire logic [pbs_pkg::DATA_W-1:0]  dataIn,
    output logic      [pbs_pkg::DATA_W-1:0]  dataOut,
    output logic                             dataOe
);
    import pbs_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    pbs_state_t s_r;
    pbs_state_t s_nxt;

    logic              active;
    logic              selected;
    logic              doLoad;
    logic              doDeselect;
    logic              doAdvance;
    logic [LANES-1:0]  inLanes;
    logic [BURST_W-1:0] nextCnt;
    logic [DATA_W-1:0] arrRd;
    logic [DATA_W-1:0] fwdRd;

    // ****************************************************************
    // command decode
    // ****************************************************************
    assign active     = ~clockEnable_n;                                // RULE8
    assign selected   = ~chipSelect_n & chipSelectSecond
                        & ~chipSelectThird_n & ~sleepRequest;          // RULE15
    assign doLoad     = active & ~loadAdvance & selected;              // RULE1
    assign doDeselect = active & ~loadAdvance & ~selected;             // RULE13
    assign doAdvance  = active & loadAdvance & s_r.burstOn;            // RULE19
    assign inLanes    = {~upperByteWrite_n, ~lowerByteWrite_n};        // RULE3
    assign nextCnt    = s_r.burstCnt + BURST_ONE;                      // RULE23

    // ****************************************************************
    // array
    // ****************************************************************
    pbs_array u_array (
        .sys_clk (sys_clk),
        .wrEn    (active & s_r.cValid),
        .wrAddr  (s_r.cAddr),
        .wrLanes (s_r.cLanes),
        .wrData  (s_r.cData),
        .rdAddr  (s_r.aAddr),
        .rdData  (arrRd)
    );

    // newest data wins: bus word of the write in stage b, then stage c
    always_comb begin
        fwdRd = arrRd;
        if (s_r.cValid && s_r.cAddr == s_r.aAddr) begin
            fwdRd = pbs_merge(fwdRd, s_r.cData, s_r.cLanes);
        end
        if (s_r.bValid && s_r.bWrite && s_r.bAddr == s_r.aAddr) begin
            fwdRd = pbs_merge(fwdRd, dataIn, s_r.bLanes);
        end
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.oeGate = ~outputEnable_n & ~sleepRequest;                // RULE16
        if (active) begin
            // stage a: command accepted this edge
            s_nxt.aValid = 1'b0;
            s_nxt.aLanes = LANE_RST;
            if (doLoad) begin
                s_nxt.burstOn    = 1'b1;                               // RULE18
                s_nxt.burstWr    = ~readNotWrite;                      // RULE10
                s_nxt.burstBase  = address[ADDR_W-1:BURST_W];
                s_nxt.burstStart = address[BURST_W-1:0];               // RULE2
                s_nxt.burstCnt   = BURST_RST;
                s_nxt.aValid     = 1'b1;
                s_nxt.aWrite     = ~readNotWrite;
                s_nxt.aAddr      = address;                            // RULE1
                s_nxt.aLanes     = readNotWrite ? LANE_RST : inLanes;  // RULE5
            end else if (doDeselect) begin
                s_nxt.burstOn = 1'b0;                                  // RULE13
            end else if (doAdvance) begin
                // address and direction pins are not looked at here
                s_nxt.burstCnt = nextCnt;                              // RULE20
                s_nxt.aValid   = 1'b1;
                s_nxt.aWrite   = s_r.burstWr;                          // RULE10
                s_nxt.aAddr    = {s_r.burstBase,
                                  pbs_burst_addr(s_r.burstStart, nextCnt,
                                                 burstOrder)};         // RULE21
                s_nxt.aLanes   = s_r.burstWr ? inLanes : LANE_RST;     // RULE5
            end
            // stage b: data cycle of the command
            s_nxt.bValid = s_r.aValid;
            s_nxt.bWrite = s_r.aWrite;
            s_nxt.bAddr  = s_r.aAddr;
            s_nxt.bLanes = s_r.aLanes;
            // read data lands in the output register for the data cycle
            s_nxt.drive  = s_r.aValid & ~s_r.aWrite;                   // RULE14
            if (s_r.aValid && !s_r.aWrite) begin
                s_nxt.rdData = fwdRd;                                  // RULE22
            end
            // stage c: write data registered from the bus
            s_nxt.cValid = s_r.bValid & s_r.bWrite & (|s_r.bLanes);
            s_nxt.cAddr  = s_r.bAddr;
            s_nxt.cLanes = s_r.bLanes;
            s_nxt.cData  = dataIn;                                     // RULE6
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r.burstOn    <= 1'b0;
            s_r.burstWr    <= 1'b0;
            s_r.burstBase  <= ADDR_RST[ADDR_W-1:BURST_W];
            s_r.burstStart <= BURST_RST;
            s_r.burstCnt   <= BURST_RST;
            s_r.aValid     <= 1'b0;
            s_r.aWrite     <= 1'b0;
            s_r.aAddr      <= ADDR_RST;
            s_r.aLanes     <= LANE_RST;
            s_r.bValid     <= 1'b0;
            s_r.bWrite     <= 1'b0;
            s_r.bAddr      <= ADDR_RST;
            s_r.bLanes     <= LANE_RST;
            s_r.cValid     <= 1'b0;
            s_r.cAddr      <= ADDR_RST;
            s_r.cLanes     <= LANE_RST;
            s_r.cData      <= DATA_RST;
            s_r.rdData     <= DATA_RST;
            s_r.drive      <= 1'b0;
            s_r.oeGate     <= 1'b0;
        end else begin
            s_r <= s_nxt;                                              // RULE12
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign dataOut = s_r.rdData;                                       // RULE11
    // output enable acts without the clock, so it gates the drive here
    assign dataOe  = s_r.drive & ~outputEnable_n & ~sleepRequest;      // RULE16

endmodule

// >>> pbs_sram_port_properties.sv
`timescale 1ns/1ps

module pbs_sram_port_checker (
    // clock and reset
    input wire logic                       sys_clk,
    input wire logic                       arst_n,
    // command inputs
    input wire logic                       loadAdvance,
    input wire logic                       readNotWrite,
    input wire logic                       clockEnable_n,
    input wire logic                       chipSelect_n,
    input wire logic                       chipSelectSecond,
    input wire logic                       chipSelectThird_n,
    input wire logic                       outputEnable_n,
    input wire logic                       sleepRequest,
    // data bus
    input wire logic [pbs_pkg::DATA_W-1:0] dataOut,
    input wire logic                       dataOe
);
    import pbs_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    logic sel;
    logic ok;
    assign sel = !chipSelect_n && chipSelectSecond && !chipSelectThird_n;
    assign ok = !outputEnable_n && !sleepRequest;
    // ****************************************************************
    // commands
    // ****************************************************************
    sequence s_rd;
        !clockEnable_n && !loadAdvance && readNotWrite && sel && !sleepRequest;
    endsequence
    sequence s_wr;
        !clockEnable_n && !loadAdvance && !readNotWrite && sel;
    endsequence
    sequence s_ds;
        !clockEnable_n && !loadAdvance && !sel;
    endsequence
    // ****************************************************************
    // properties
    // ****************************************************************
    property p_rd; s_rd ##1 !clockEnable_n ##1 ok |-> dataOe; endproperty
    property p_wr; s_wr ##1 !clockEnable_n |=> !dataOe; endproperty
    property p_ds; s_ds ##1 !clockEnable_n |=> !dataOe; endproperty
    property p_frz_rd;
        s_rd ##1 clockEnable_n ##1 !clockEnable_n ##1 ok |-> dataOe;
    endproperty
    property p_frz_out; clockEnable_n |=> $stable(dataOut); endproperty
    property p_frz_oe; clockEnable_n && ok ##1 ok |-> $stable(dataOe);
    endproperty
    property p_oe; outputEnable_n |-> !dataOe; endproperty
    property p_sleep; sleepRequest |-> !dataOe; endproperty
    a_rd: assert property (p_rd) else $error("read not driven");
    a_wr: assert property (p_wr) else $error("bus driven in write");
    a_ds: assert property (p_ds) else $error("bus after deselect");
    a_frz_rd: assert property (p_frz_rd) else $error("stall lost");
    a_frz_out: assert property (p_frz_out) else $error("data moved");
    a_frz_oe: assert property (p_frz_oe) else $error("enable moved");
    a_oe: assert property (p_oe) else $error("driven with oe high");
    a_sleep: assert property (p_sleep) else $error("driven asleep");
    c_rd: cover property (s_rd ##1 clockEnable_n);
endmodule

bind pbs_sram_port pbs_sram_port_checker u_pbs_sram_port_checker (
    .sys_clk(sys_clk), .arst_n(arst_n), .loadAdvance(loadAdvance),
    .readNotWrite(readNotWrite), .clockEnable_n(clockEnable_n),
    .chipSelect_n(chipSelect_n), .chipSelectSecond(chipSelectSecond),
    .chipSelectThird_n(chipSelectThird_n), .outputEnable_n(outputEnable_n),
    .sleepRequest(sleepRequest), .dataOut(dataOut), .dataOe(dataOe));

// >>> pbs_ctrl_model.sv
`timescale 1ns/1ps

module pbs_ctrl_model (
    // clock
    input  wire logic                       sys_clk,
    input  wire logic                       clockEnable_n,
    // write request
    input  wire logic                       wrNow,
    input  wire logic [pbs_pkg::DATA_W-1:0] wrWord,
    // device side
    input  wire logic [pbs_pkg::DATA_W-1:0] dataOut,
    input  wire logic                       dataOe,
    output logic      [pbs_pkg::DATA_W-1:0] dataIn
);
    import pbs_pkg::*;
    logic [DATA_W:0]   s0 = '0;
    logic [DATA_W:0]   s1 = '0;
    logic [DATA_W-1:0] last = '0;
    // write word lands two enabled edges after its command
    always @(posedge sys_clk) if (!clockEnable_n) begin
        s1 <= s0;
        s0 <= {wrNow, wrWord};
    end
    // released bus toggles every cycle
    always_comb dataIn = s1[DATA_W] ? s1[DATA_W-1:0] : dataOe ? dataOut : ~last;
    always @(posedge sys_clk) last <= dataIn;
endmodule

// >>> test_pipelined_burst_sram_port.sv
`timescale 1ns/1ps

module test_pipelined_burst_sram_port;
    import pbs_pkg::*;
    localparam logic [4:0] SEL = 5'h08;
    logic              sys_clk = 0;
    logic              arst_n = 0;
    logic [ADDR_W-1:0] address = '0;
    logic              loadAdvance = 1;
    logic              readNotWrite = 1;
    logic [1:0]        laneWrite_n = 2'h3;
    logic              clockEnable_n = 0;
    logic [4:0]        ctl = SEL;
    logic              burstOrder = 1;
    logic [DATA_W-1:0] dataIn;
    logic [DATA_W-1:0] dataOut;
    logic              dataOe;
    logic              wrNow = 0;
    logic [DATA_W-1:0] wrWord = '0;
    logic [DATA_W:0]   eNow = '0;
    logic [DATA_W:0]   e0 = '0;
    logic [DATA_W:0]   e1 = '0;
    logic [DATA_W-1:0] mem [16];
    logic              bOn = 0;
    logic              bWr = 0;
    logic [3:0]        bAd = '0;
    logic [1:0]        bCnt = '0;
    logic [31:0]       r;
    int                n_errors = 0;
    int                num_checks = 0;
    always #12.5 sys_clk = ~sys_clk;
    pbs_sram_port u_pbs_sram_port (.sys_clk(sys_clk), .arst_n(arst_n),
        .address(address), .loadAdvance(loadAdvance),
        .readNotWrite(readNotWrite), .lowerByteWrite_n(laneWrite_n[0]),
        .upperByteWrite_n(laneWrite_n[1]), .clockEnable_n(clockEnable_n),
        .chipSelect_n(ctl[4]), .chipSelectSecond(ctl[3]),
        .chipSelectThird_n(ctl[2]), .outputEnable_n(ctl[1]),
        .sleepRequest(ctl[0]), .burstOrder(burstOrder), .dataIn(dataIn),
        .dataOut(dataOut), .dataOe(dataOe));
    pbs_ctrl_model u_pbs_ctrl_model (.sys_clk(sys_clk),
        .clockEnable_n(clockEnable_n), .wrNow(wrNow), .wrWord(wrWord),
        .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn));
    // ****************************************************************
    // checking
    // ****************************************************************
    task automatic chk(input logic [DATA_W-1:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [DATA_W-1:0] mrg(input logic [DATA_W-1:0] o, n,
        input logic [1:0] ln);
        mrg = o;
        if (!ln[0]) mrg[8:0] = n[8:0];
        if (!ln[1]) mrg[17:9] = n[17:9];
    endfunction
    always @(posedge sys_clk) begin
        if (!arst_n) begin
            e0 <= '0;
            e1 <= '0;
        end else if (!clockEnable_n) begin
            e1 <= e0;
            e0 <= eNow;
        end
    end
    always @(negedge sys_clk) if (arst_n) begin
        chk(dataOe, e1[DATA_W] & ~ctl[1] & ~ctl[0]);
        if (e1[DATA_W] && dataOe === 1'b1) chk(dataOut, e1[DATA_W-1:0]);
    end
    // ****************************************************************
    // stimulus and reference
    // ****************************************************************
    task automatic cyc(input logic ld, rnw, input logic [3:0] a,
        input logic [1:0] ln, input logic clock_enable_n, input logic [4:0] c);
        logic [3:0]        wa;
        logic [DATA_W-1:0] w;
        logic              hit;
        @(posedge sys_clk);
        {loadAdvance, readNotWrite, laneWrite_n, clockEnable_n, ctl} <=
            {ld, rnw, ln, clock_enable_n, c};
        address <= {15'h0000, a};
        if (!clock_enable_n && !ld) begin
            bOn = c[4:2] == 3'h2 && !c[0];
            bWr = !rnw;
            bAd = a;
            bCnt = 2'h0;
        end else if (!clock_enable_n && bOn) begin
            bCnt = bCnt + 2'h1;
        end
        hit = !clock_enable_n && bOn;
        wa = {bAd[3:2], burstOrder ? bAd[1:0] ^ bCnt : bAd[1:0] + bCnt};
        w = DATA_W'($urandom);
        wrWord <= w;
        wrNow <= hit && bWr;
        eNow <= {hit && !bWr, mem[wa]};
        if (hit && bWr) mem[wa] = mrg(mem[wa], w, ln);
    endtask
    initial begin
        repeat (8000) @(posedge sys_clk);
        n_errors++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'h0000_4555));
        repeat (8) @(posedge sys_clk);
        arst_n <= 1;
        for (int i = 0; i < 16; i++) cyc(0, 0, i[3:0], 2'h0, 0, SEL);
        cyc(0, 1, 4'h5, 2'h0, 0, SEL);
        cyc(1, 0, 4'hf, 2'h0, 0, SEL);
        cyc(1, 0, 4'h0, 2'h0, 1, SEL);
        cyc(1, 0, 4'h0, 2'h0, 0, SEL);
        cyc(1, 0, 4'h0, 2'h0, 0, 5'h0a);
        cyc(0, 1, 4'h6, 2'h0, 0, 5'h09);
        cyc(0, 1, 4'h7, 2'h0, 0, 5'h18);
        cyc(1, 1, 4'h7, 2'h0, 0, SEL);
        cyc(0, 1, 4'h8, 2'h0, 0, 5'h00);
        cyc(1, 1, 4'h8, 2'h0, 0, SEL);
        cyc(0, 1, 4'h9, 2'h0, 0, 5'h0c);
        cyc(1, 1, 4'h9, 2'h0, 0, SEL);
        for (int p = 0; p < 2; p++) begin
            burstOrder <= p[0];
            for (int i = 0; i < 1500; i++) begin
                r = $urandom;
                cyc(r[0], r[1], r[5:2], r[7:6], r[11:8] == 4'h0,
                    r[15:12] == 4'h0 ? 5'h18 : {3'h2, r[18:16] == 3'h0,
                    !r[0] && r[21:19] == 3'h0});
            end
            cyc(0, 1, 4'h0, 2'h0, 0, 5'h18);
        end
        repeat (3) cyc(1, 1, 4'h0, 2'h0, 0, SEL);
        wrap_up();
    end
endmodule
